// *** hdl/rxf_filter.sv ***
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// R01: save_errored_frames keeps CRC/alignment errored frames
// R02: accept_short_frames keeps frames under 64 bytes
// R03: accept_all_ones_dest keeps broadcast frames
// R04: group_address_check enables multicast hash check
// R05: physical address must match unless promiscuous
// R06: monitor checks frames but stores none
// R07: monitor counts each recognized frame as missed
// R08: software writes config bit 6 as zero
// R09: acceptance criteria combine by logical OR
// R10: full promiscuous needs three bits plus hash
// R11: status byte written after good frame
// R12: errored frames carry status only when saved
// R13: status clears when next frame starts
// R14: intact only when all error flags zero
// R15: CRC mismatch sets bit 1, counts
// R16: misaligned with bad CRC sets bit 2
// R17: FIFO overflow sets bit 3, aborts frame
// R18: unstored addressed frame sets missed, counts
// R19: bit 5 tells physical or group match
// R20: bit 6 follows monitor receiver disable
// R21: bit 7 set by carrier or collision
// R22: CRC/alignment pair encodes error type
// R23: tallies saturate at 192, clear on read
// R24: unaccepted frames write nothing to memory; rejected runt or errored frames are stored, then discarded
module rxf_filter
  import rxf_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  // decoded receive stream from the line decoder
  input  wire logic        rx_start,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_end,
  input  wire logic        rx_crc_ok,
  input  wire logic [2:0]  rx_dribble_bits,
  input  wire logic        rx_fifo_overflow,
  input  wire logic        group_hash_hit,
  input  wire logic        buffers_full,
  // media pins
  input  wire logic        carrier_pin,
  input  wire logic        collision_detect_line,
  // local DMA side
  output logic             dma_dest_valid,
  output logic [47:0]      dma_dest,
  output logic             dma_byte_valid,
  output logic [7:0]       dma_byte,
  output logic             dma_status_valid,
  output logic [7:0]       dma_status,
  output logic             dma_commit,
  output logic             dma_discard
);
  import rxf_pkg::*;

  rxf_state_t  state;
  rxf_state_t  next_state;
  logic [7:0]  receive_filter_config;
  logic [7:0]  receive_frame_status;
  logic [7:0]  station_address_bytes [STATION_BYTES];
  logic [47:0] dest_shift;
  logic [2:0]  dest_count;
  logic [6:0]  frame_len;
  logic        storing;
  logic        hit_seen;
  logic [1:0]  crs_sync;
  logic [1:0]  col_sync;

  rxf_tally_if align_tif ();
  rxf_tally_if crc_tif ();
  rxf_tally_if miss_tif ();

  // configuration fields
  wire save_errored_frames  = receive_filter_config[CFG_SAVE_ERRORED];
  wire accept_short_frames  = receive_filter_config[CFG_ACCEPT_SHORT];
  wire accept_all_ones_dest = receive_filter_config[CFG_ACCEPT_ONES];
  wire group_address_check  = receive_filter_config[CFG_GROUP_CHECK];
  wire accept_any_station   = receive_filter_config[CFG_ANY_STATION];
  wire monitor_only         = receive_filter_config[CFG_MONITOR_ONLY];

  // register decode
  wire wr_config   = reg_wr & (reg_addr == REG_CONFIG);
  wire rd_align    = reg_rd & (reg_addr == REG_ALIGN_TALLY);
  wire rd_crc      = reg_rd & (reg_addr == REG_CRC_TALLY);
  wire rd_miss     = reg_rd & (reg_addr == REG_MISS_TALLY);
  wire [3:0] st_ix = reg_addr - REG_STATION0;
  wire st_sel      = (reg_addr >= REG_STATION0) &&
                     (st_ix < 4'(STATION_BYTES));

  // address filter sees the collected destination
  wire [47:0] station_flat = {station_address_bytes[0],
                              station_address_bytes[1],
                              station_address_bytes[2],
                              station_address_bytes[3],
                              station_address_bytes[4],
                              station_address_bytes[5]};
  wire [47:0] dest_now = {dest_shift[39:0], rx_byte};
  logic addr_hit;
  logic addr_group;

  rxf_addr_match u_match (
    .dest                 (dest_now),
    .station              (station_flat),
    .accept_all_ones_dest (accept_all_ones_dest),
    .group_address_check  (group_address_check),
    .accept_any_station   (accept_any_station),
    .group_hash_hit       (group_hash_hit),
    .hit                  (addr_hit),
    .is_group             (addr_group)
  );

  // destination complete on the sixth byte
  wire dest_done = (state == RXF_DEST) & rx_byte_valid &
                   (dest_count == 3'(STATION_BYTES - 1));
  // R06: monitor never stores
  // R18: no buffers means not stored
  wire will_store = addr_hit & ~monitor_only & ~buffers_full;
  // R07: recognized frames counted when unstored
  wire missed_now = dest_done & addr_hit & ~will_store;

  // end of frame evaluation
  wire frame_end  = rx_end & (state != RXF_IDLE);
  // address recognized, stored or not: monitor and full-buffer frames
  // still feed the error tallies
  wire recognized = hit_seen;
  // R22: only none, CRC, or CRC plus alignment
  wire crc_flag   = ~rx_crc_ok | (rx_dribble_bits >= DRIBBLE_LIMIT);
  // R16: alignment needs dribble and failed CRC
  wire align_flag = crc_flag & (rx_dribble_bits != 3'h0);
  wire err_flag   = crc_flag | align_flag;
  // R02: runt check on frame length
  wire is_short   = (frame_len < MIN_FRAME_BYTES);
  // R01: errored frames only kept when saving
  // R12: rejected errored frames leave no status
  wire keep_frame = (state == RXF_BODY) &
                    ~receive_frame_status[ST_OVERFLOW] &
                    (~err_flag | save_errored_frames) &
                    (~is_short | accept_short_frames);

  // R17: overflow aborts storing at once
  wire overflow_hit = rx_fifo_overflow & (state != RXF_IDLE);

  // next state
  always_comb begin
    next_state = state;
    case (state)
      RXF_IDLE: begin
        if (rx_start) begin
          next_state = RXF_DEST;
        end
      end
      RXF_DEST: begin
        if (rx_end) begin
          next_state = RXF_IDLE;
        end else if (overflow_hit) begin
          next_state = RXF_SKIP;
        end else if (dest_done) begin
          // R24: unmatched frames go to skip
          next_state = will_store ? RXF_BODY : RXF_SKIP;
        end
      end
      RXF_BODY: begin
        if (rx_end) begin
          next_state = RXF_IDLE;
        end else if (overflow_hit) begin
          next_state = RXF_SKIP;
        end
      end
      RXF_SKIP: begin
        if (rx_end) begin
          next_state = RXF_IDLE;
        end
      end
      default: next_state = RXF_IDLE;
    endcase
  end

  // state and frame counters
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state      <= RXF_IDLE;
      dest_shift <= 48'h0;
      dest_count <= 3'h0;
      frame_len  <= 7'h00;
      storing    <= 1'b0;
      hit_seen   <= 1'b0;
    end else begin
      state <= next_state;
      if (rx_start) begin
        dest_count <= 3'h0;
        frame_len  <= 7'h00;
        storing    <= 1'b0;
        hit_seen   <= 1'b0;
      end else if (rx_byte_valid) begin
        if (state == RXF_DEST) begin
          dest_shift <= dest_now;
          dest_count <= dest_count + 3'h1;
        end
        // saturate, only the runt test reads it
        if (frame_len != MIN_FRAME_BYTES) begin
          frame_len <= frame_len + 7'h01;
        end
      end
      if (dest_done) begin
        storing  <= will_store;
        hit_seen <= addr_hit;
      end
    end
  end

  // two flops before media pins are looked at
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      crs_sync <= 2'b00;
      col_sync <= 2'b00;
    end else begin
      crs_sync <= {crs_sync[0], carrier_pin};
      col_sync <= {col_sync[0], collision_detect_line};
    end
  end
  wire media_busy = crs_sync[1] | col_sync[1];

  // status byte; setting events win over the frame-start clear
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      receive_frame_status <= STATUS_RESET;
    end else begin
      // R13: cleared on next frame start
      if (rx_start) begin
        receive_frame_status <= STATUS_RESET;
      end
      // R20: disable follows monitor operation
      receive_frame_status[ST_DISABLED] <= monitor_only;
      // R21: carrier or collision, held until the next frame start
      if (media_busy) begin
        receive_frame_status[ST_DEFERRING] <= 1'b1;
      end
      // R17: overflow flag
      if (overflow_hit) begin
        receive_frame_status[ST_OVERFLOW] <= 1'b1;
      end
      if (dest_done) begin
        // R19: physical 0, group 1
        receive_frame_status[ST_MATCH] <= addr_group;
        // R18: missed flag
        receive_frame_status[ST_MISSED] <= missed_now;
      end
      if (frame_end) begin
        // R15: CRC flag also on alignment
        receive_frame_status[ST_CRC]   <= err_flag;
        receive_frame_status[ST_ALIGN] <= align_flag;
        // R14: intact only with no error flags
        receive_frame_status[ST_INTACT] <= ~err_flag &
          ~receive_frame_status[ST_OVERFLOW] &
          ~receive_frame_status[ST_MISSED] & ~overflow_hit;
      end
    end
  end

  // tally hookups; tallies only count recognized frames
  // R15: CRC tally
  assign crc_tif.inc    = frame_end & recognized & crc_flag & ~align_flag;
  // R16: alignment tally
  assign align_tif.inc  = frame_end & recognized & align_flag;
  // R18: missed tally
  assign miss_tif.inc   = missed_now;
  assign crc_tif.clr    = rd_crc;
  assign align_tif.clr  = rd_align;
  assign miss_tif.clr   = rd_miss;

  rxf_tally u_align_tally (
    .sys_clk (sys_clk),
    .srst    (srst),
    .tif     (align_tif)
  );
  rxf_tally u_crc_tally (
    .sys_clk (sys_clk),
    .srst    (srst),
    .tif     (crc_tif)
  );
  rxf_tally u_miss_tally (
    .sys_clk (sys_clk),
    .srst    (srst),
    .tif     (miss_tif)
  );

  // DMA outputs, all registered
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dma_dest_valid   <= 1'b0;
      dma_dest         <= 48'h0;
      dma_byte_valid   <= 1'b0;
      dma_byte         <= 8'h00;
      dma_status_valid <= 1'b0;
      dma_commit       <= 1'b0;
      dma_discard      <= 1'b0;
    end else begin
      dma_dest_valid <= dest_done & will_store & ~overflow_hit & ~rx_end;
      if (dest_done) begin
        dma_dest <= dest_now;
      end
      dma_byte_valid <= rx_byte_valid & (state == RXF_BODY) &
                        ~overflow_hit;
      if (rx_byte_valid) begin
        dma_byte <= rx_byte;
      end
      // R11: status after a kept frame
      dma_status_valid <= frame_end & keep_frame & ~overflow_hit;
      dma_commit       <= frame_end & keep_frame & ~overflow_hit;
      // R24: partial stores are rolled back
      dma_discard <= (storing & (state == RXF_BODY) &
                      (overflow_hit | (frame_end & ~keep_frame)));
    end
  end
  // status byte shown to the DMA as it will stand after this frame
  assign dma_status = receive_frame_status;

  // register writes; bit 6 and 7 are not stored
  // R08: reserved config bits ignored
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      receive_filter_config <= CFG_RESET;
      for (int i = 0; i < STATION_BYTES; i++) begin
        station_address_bytes[i] <= 8'h00;
      end
    end else begin
      if (wr_config) begin
        receive_filter_config <= reg_wdata & CFG_WRITABLE;
      end
      if (reg_wr & st_sel) begin
        station_address_bytes[st_ix[2:0]] <= reg_wdata;
      end
    end
  end

  // read mux; unmapped offsets read zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      REG_CONFIG:      rd_mux = receive_filter_config;
      REG_STATUS:      rd_mux = receive_frame_status;
      REG_ALIGN_TALLY: rd_mux = align_tif.count;
      REG_CRC_TALLY:   rd_mux = crc_tif.count;
      REG_MISS_TALLY:  rd_mux = miss_tif.count;
      default: begin
        if (st_sel) begin
          rd_mux = station_address_bytes[st_ix[2:0]];
        end
      end
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end
endmodule
`default_nettype wire

// *** hdl/rxf_pkg.sv ***
package rxf_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] REG_CONFIG      = 4'h0;
  localparam logic [3:0] REG_STATUS      = 4'h1;
  localparam logic [3:0] REG_ALIGN_TALLY = 4'h2;
  localparam logic [3:0] REG_CRC_TALLY   = 4'h3;
  localparam logic [3:0] REG_MISS_TALLY  = 4'h4;
  localparam logic [3:0] REG_STATION0    = 4'h5;
  localparam int         STATION_BYTES   = 6;
  // receive_filter_config fields
  localparam int CFG_SAVE_ERRORED  = 0;
  localparam int CFG_ACCEPT_SHORT  = 1;
  localparam int CFG_ACCEPT_ONES   = 2;
  localparam int CFG_GROUP_CHECK   = 3;
  localparam int CFG_ANY_STATION   = 4;
  localparam int CFG_MONITOR_ONLY  = 5;
  localparam logic [7:0] CFG_WRITABLE = 8'h3f;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  // receive_frame_status fields
  localparam int ST_INTACT    = 0;
  localparam int ST_CRC       = 1;
  localparam int ST_ALIGN     = 2;
  localparam int ST_OVERFLOW  = 3;
  localparam int ST_MISSED    = 4;
  localparam int ST_MATCH     = 5;
  localparam int ST_DISABLED  = 6;
  localparam int ST_DEFERRING = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // frame limits
  localparam logic [6:0] MIN_FRAME_BYTES = 7'h40;
  localparam logic [2:0] DRIBBLE_LIMIT   = 3'h6;
  localparam logic [7:0] TALLY_MAX       = 8'hc0;
  localparam logic [7:0] GROUP_BIT_MASK  = 8'h01;
  typedef enum logic [1:0] {
    RXF_IDLE,
    RXF_DEST,
    RXF_BODY,
    RXF_SKIP
  } rxf_state_t;
endpackage

// *** hdl/rxf_tally_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface rxf_tally_if;
  logic       inc;
  logic       clr;
  logic [7:0] count;
  modport owner (output inc, output clr, input count);
  modport counter (input inc, input clr, output count);
endinterface
`default_nettype wire

// *** hdl/rxf_tally.sv ***
`timescale 1ns/10ps
`default_nettype none
module rxf_tally (
  input wire logic      sys_clk,
  input wire logic      srst,
  rxf_tally_if.counter  tif
);
  import rxf_pkg::*;
  logic [7:0] next_count;

  // increment wins over a read clear so no event is lost
  // R23: saturate, read clear
  assign next_count = tif.inc ? ((tif.clr) ? 8'h01 :
                        ((tif.count == TALLY_MAX) ? TALLY_MAX :
                         tif.count + 8'h01)) :
                      (tif.clr ? 8'h00 : tif.count);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tif.count <= 8'h00;
    end else begin
      tif.count <= next_count;
    end
  end
endmodule
`default_nettype wire

// *** hdl/rxf_addr_match.sv ***
`timescale 1ns/10ps
`default_nettype none
module rxf_addr_match (
  input  wire logic [47:0] dest,
  input  wire logic [47:0] station,
  input  wire logic        accept_all_ones_dest,
  input  wire logic        group_address_check,
  input  wire logic        accept_any_station,
  input  wire logic        group_hash_hit,
  output logic             hit,
  output logic             is_group
);
  import rxf_pkg::*;
  wire is_ones     = (dest == {48{1'b1}});
  wire group_bit   = |(dest[47:40] & GROUP_BIT_MASK);
  wire own_station = (dest == station);

  // R03: broadcast acceptance
  wire ones_ok  = is_ones & accept_all_ones_dest;
  // R04: multicast check
  wire group_ok = group_bit & ~is_ones & group_address_check &
                  group_hash_hit;
  // R05: physical station compare
  wire phys_ok  = ~group_bit & (accept_any_station | own_station);

  // R09: criteria are ORed
  assign hit      = ones_ok | group_ok | phys_ok;
  assign is_group = group_bit;
endmodule
`default_nettype wire

// *** bench/rxf_props.sv ***
`timescale 1ns/10ps
`default_nettype none
// port-level checks of the receive filter
module rxf_props
  import rxf_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        srst,
  input wire logic        rx_byte_valid,
  input wire logic [7:0]  rx_byte,
  input wire logic        carrier_pin,
  input wire logic        dma_dest_valid,
  input wire logic [47:0] dma_dest,
  input wire logic        dma_byte_valid,
  input wire logic [7:0]  dma_byte,
  input wire logic        dma_status_valid,
  input wire logic [7:0]  dma_status,
  input wire logic        dma_commit,
  input wire logic        dma_discard
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  AST_MON_QUIET: assert property (
    dma_status[ST_DISABLED] |->
      !(dma_dest_valid || dma_byte_valid || dma_commit))
    else $error("memory written while monitoring");
  AST_INTACT: assert property (
    dma_status_valid |->
      dma_status[ST_INTACT] == (dma_status[4:1] == 4'h0))
    else $error("intact flag disagrees with errors");
  AST_CRC_PAIR: assert property (
    dma_status_valid |->
      !(dma_status[ST_ALIGN] && !dma_status[ST_CRC]))
    else $error("alignment without crc flag");
  AST_STATUS_COMMIT: assert property (
    (dma_commit || dma_status_valid) |->
      (dma_commit && dma_status_valid))
    else $error("status and commit apart");
  AST_ONE_END: assert property (
    (dma_commit || dma_discard) |->
      !(dma_commit && dma_discard) ##1 !(dma_commit || dma_discard))
    else $error("frame end not a single pulse");
  AST_DEST_LAST: assert property (
    dma_dest_valid |->
      $past(rx_byte_valid) && dma_dest[7:0] == $past(rx_byte))
    else $error("dest not from sixth byte");
  AST_BYTE_PASS: assert property (
    dma_byte_valid |-> $past(rx_byte_valid) && dma_byte == $past(rx_byte))
    else $error("stored byte differs");
  AST_DEFER: assert property (
    carrier_pin [*4] |-> ##[0:3] dma_status[ST_DEFERRING])
    else $error("carrier not flagged");
endmodule
`default_nettype wire

// *** bench/rxf_media_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// decoded frame stream as a remote station sends it
module rxf_media_model (
  input  wire logic       sys_clk,
  output logic            rx_start,
  output logic            rx_byte_valid,
  output logic [7:0]      rx_byte,
  output logic            rx_end,
  output logic            rx_crc_ok,
  output logic [2:0]      rx_dribble_bits,
  output logic            rx_fifo_overflow
);
  // idle line until the first frame
  initial begin
    {rx_start, rx_byte_valid, rx_end, rx_fifo_overflow} = 4'h0;
    {rx_byte, rx_crc_ok, rx_dribble_bits} = 12'h0;
  end

  // start, bytes dest first, then end with crc verdict
  task automatic send(input logic [47:0] d, input int len,
                      input logic ok, input logic [2:0] db,
                      input logic ovf);
    @(posedge sys_clk);
    rx_start <= 1'b1;
    for (int i = 0; i < len; i++) begin
      @(posedge sys_clk);
      rx_start <= 1'b0;
      rx_byte_valid <= 1'b1;
      rx_byte <= (i < 6) ? d[47-8*i -: 8] : i[7:0];
      rx_fifo_overflow <= ovf && i == 20;
    end
    @(posedge sys_clk);
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;  // released line shows junk
    rx_fifo_overflow <= 1'b0;
    rx_end <= 1'b1;
    rx_crc_ok <= ok;
    rx_dribble_bits <= db;
    @(posedge sys_clk);
    rx_end <= 1'b0;
    rx_crc_ok <= ~ok;
    rx_dribble_bits <= ~db;
  endtask
endmodule
`default_nettype wire

// *** bench/test_rx_filter_and_status.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module test_rx_filter_and_status;
  import rxf_pkg::*;
  localparam logic [47:0] STA = 48'h0211_2233_4455;
  localparam logic [47:0] OTH = 48'h0211_2233_4456;
  localparam logic [47:0] BC  = 48'hffff_ffff_ffff;
  localparam logic [47:0] MC  = 48'h0100_5e00_0001;
  logic        sys_clk, srst, reg_wr, reg_rd, group_hash_hit;
  logic        buffers_full, carrier_pin, collision_detect_line;
  logic        rx_start, rx_byte_valid, rx_end, rx_crc_ok;
  logic        rx_fifo_overflow, dma_dest_valid, dma_byte_valid;
  logic        dma_status_valid, dma_commit, dma_discard;
  logic [2:0]  rx_dribble_bits;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rx_byte, dma_byte, dma_status;
  logic [7:0]  last_st, v;
  logic [47:0] dma_dest, last_dest;
  int          num_errors, n_tests, n_commit, n_byte, n_disc;

  rxf_filter u_dut (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .rx_start, .rx_byte_valid, .rx_byte, .rx_end,
    .rx_crc_ok, .rx_dribble_bits, .rx_fifo_overflow, .group_hash_hit,
    .buffers_full, .carrier_pin, .collision_detect_line, .dma_dest_valid,
    .dma_dest, .dma_byte_valid, .dma_byte, .dma_status_valid,
    .dma_status, .dma_commit, .dma_discard);
  rxf_media_model u_med (.sys_clk, .rx_start, .rx_byte_valid, .rx_byte,
    .rx_end, .rx_crc_ok, .rx_dribble_bits, .rx_fifo_overflow);

  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // tally what the dma side is handed
  always @(posedge sys_clk) begin
    if (dma_commit === 1'b1) n_commit++;
    if (dma_discard === 1'b1) n_disc++;
    if (dma_byte_valid === 1'b1) n_byte++;
    if (dma_dest_valid === 1'b1) last_dest = dma_dest;
    if (dma_status_valid === 1'b1) last_st = dma_status;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // data is only valid in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    // taken at the edge that closes the data cycle
    @(posedge sys_clk);
    d = reg_rdata;
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask

  // st of zero means nothing may be committed
  task automatic frame(input logic [47:0] d, input int len,
                       input logic ok, input logic [2:0] db,
                       input logic ovf, input logic [7:0] st);
    int c, b;
    c = n_commit;
    b = n_byte;
    u_med.send(d, len, ok, db, ovf);
    repeat (3) @(posedge sys_clk);
    if (st == 8'h00) begin
      `CHK(n_commit - c, 0)
    end else begin
      `CHK(n_commit - c, 1)
      `CHK(last_st, st)
      `CHK(last_dest, d)
      `CHK(n_byte - b, len - 6)
    end
  endtask

  task stop_test;
    if (num_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    stop_test();
  end

  initial begin
    {srst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 14'h0};
    {group_hash_hit, buffers_full} = 2'b00;
    {carrier_pin, collision_detect_line} = 2'b00;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    chk_rd(REG_CONFIG, CFG_RESET);
    wr(REG_CONFIG, 8'hbf);
    chk_rd(REG_CONFIG, 8'h3f);
    chk_rd(4'hf, 8'h00);
    for (int k = 0; k < STATION_BYTES; k++) begin
      wr(REG_STATION0 + 4'(k), STA[47-8*k -: 8]);
    end
    wr(REG_CONFIG, 8'h00);
    frame(STA, 64, 1, 0, 0, 8'h01);
    frame(OTH, 64, 1, 0, 0, 8'h00);
    frame(BC, 64, 1, 0, 0, 8'h00);
    group_hash_hit <= 1'b1;
    frame(MC, 64, 1, 0, 0, 8'h00);
    frame(STA, 63, 1, 0, 0, 8'h00);
    `CHK(n_disc, 1)
    frame(STA, 64, 0, 0, 0, 8'h00);
    `CHK(n_disc, 2)
    wr(REG_CONFIG, 8'h0f);
    frame(STA, 63, 1, 0, 0, 8'h01);
    frame(BC, 64, 1, 0, 0, 8'h21);
    frame(MC, 64, 1, 0, 0, 8'h21);
    frame(STA, 64, 0, 0, 0, 8'h02);
    frame(STA, 64, 0, 3'h3, 0, 8'h06);
    chk_rd(REG_CRC_TALLY, 8'h02);
    chk_rd(REG_ALIGN_TALLY, 8'h01);
    chk_rd(REG_CRC_TALLY, 8'h00);
    frame(STA, 64, 1, 0, 1, 8'h00);
    `CHK(n_disc, 3)
    rd(REG_STATUS, v);
    `CHK(v[ST_OVERFLOW], 1'b1)
    wr(REG_CONFIG, 8'h1c);
    frame(OTH, 64, 1, 0, 0, 8'h01);
    frame(MC, 64, 1, 0, 0, 8'h21);
    buffers_full <= 1'b1;
    frame(STA, 64, 1, 0, 0, 8'h00);
    chk_rd(REG_STATUS, 8'h10);
    buffers_full <= 1'b0;
    wr(REG_CONFIG, 8'h20);
    frame(STA, 64, 1, 0, 0, 8'h00);
    chk_rd(REG_STATUS, 8'h50);
    chk_rd(REG_MISS_TALLY, 8'h02);
    frame(OTH, 64, 1, 0, 0, 8'h00);
    chk_rd(REG_MISS_TALLY, 8'h00);
    frame(STA, 64, 0, 0, 0, 8'h00);
    chk_rd(REG_CRC_TALLY, 8'h01);
    wr(REG_CONFIG, 8'h00);
    rd(REG_STATUS, v);
    `CHK(v[ST_DISABLED], 1'b0)
    // carrier, then collision, each must raise deferring
    for (int p = 0; p < 2; p++) begin
      // a frame start clears deferring so each pin is tested alone
      frame(STA, 64, 1, 0, 0, 8'h01);
      {collision_detect_line, carrier_pin} <= p ? 2'b10 : 2'b01;
      repeat (6) @(posedge sys_clk);
      {collision_detect_line, carrier_pin} <= 2'b00;
      repeat (3) @(posedge sys_clk);
      rd(REG_STATUS, v);
      `CHK(v[ST_DEFERRING], 1'b1)
    end
    frame(STA, 64, 1, 0, 0, 8'h01);
    // one frame beyond the ceiling of the tally
    repeat (193) u_med.send(STA, 64, 0, 0, 0);
    chk_rd(REG_CRC_TALLY, TALLY_MAX);
    chk_rd(REG_CRC_TALLY, 8'h00);
    stop_test();
  end
endmodule
bind rxf_filter rxf_props u_props (.sys_clk, .srst, .rx_byte_valid,
  .rx_byte, .carrier_pin, .dma_dest_valid, .dma_dest, .dma_byte_valid,
  .dma_byte, .dma_status_valid, .dma_status, .dma_commit, .dma_discard);
`default_nettype wire
